/* src/system_option_registers.sv */
// Write-once system option registers, the non-volatile oscillator byte and the
// decode of the stored register bits and the byte's bits 7:6 into control levels for clocks, monitor and stop.
// Assumes an Avalon-MM master on mclk and a flash image that presents the byte.
//
// Design decisions made here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`include "sysopt_map.svh"

module system_option_registers
    import sysopt_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Avalon-MM slave
    input wire logic [17:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] avs_response,
    // Non-volatile byte as presented by flash
    input wire logic [7:0] nv_option_byte,
    input wire logic nv_load,
    // Events from the core
    input wire logic stop_opcode,
    input wire logic monitor_reset_req,
    input wire logic stop_exit_by_pin,
    // Option levels
    output logic [18:0] watchdog_timeout_cycles,
    output logic watchdog_module_enable,
    output logic supply_monitor_enable,
    output logic regulator_monitor_enable,
    output logic low_voltage_monitor_stop_run,
    output logic monitor_reset_out,
    output logic [12:0] stop_recovery_cycles,
    output logic stop_execute,
    output logic illegal_opcode,
    output logic internal_osc_stop_run,
    output logic internal_osc_run,
    output logic rc_osc_stop_run,
    output logic crystal_osc_stop_run,
    output timebase_src_t timebase_source_clock,
    output logic timebase_source_valid,
    output logic serial_baud_from_bus,
    output base_osc_t oscillator_base_clock,
    output logic osc_output_pin_from_bus,
    output logic osc_output_pin_from_crystal
);
    // ----------------------------------------------------------------------
    // Decode functions
    // ----------------------------------------------------------------------
    // Matches a bus byte address against the address of one register.
    function automatic logic addr_hit(input logic [17:0] addr, input logic [17:0] target);
        return addr == target;
    endfunction : addr_hit

    // Gives the watchdog timeout count for one level of the period select bit.
    function automatic logic [18:0] wdog_cycles(input logic short_sel);
        logic [18:0] cyc;
        cyc = `WDOG_LONG_CYC;
        if (short_sel) begin
            cyc = `WDOG_SHORT_CYC;
        end
        return cyc;
    endfunction : wdog_cycles

    // A reset-pin exit restarts the clocks, so it never takes the short delay.
    function automatic logic [12:0] rec_cycles(input logic short_sel, input logic pin_exit);
        logic [12:0] cyc;
        cyc = `REC_LONG_CYC;
        if (short_sel && !pin_exit) begin
            cyc = `REC_SHORT_CYC;
        end
        return cyc;
    endfunction : rec_cycles

    // The monitor can only run in stop while one of its two detectors is powered.
    function automatic logic mon_stop_runs(input logic stop_en, input logic supply_dis,
        input logic reg_dis);
        return stop_en && !(supply_dis && reg_dis);
    endfunction : mon_stop_runs

    // Reports whether a timebase select code names a real clock.
    function automatic logic tb_code_used(input timebase_src_t code);
        logic used;
        used = 1'b0;
        unique case (code)
            TB_INTERNAL: begin
                used = 1'b1;
            end
            TB_RC: begin
                used = 1'b1;
            end
            TB_CRYSTAL: begin
                used = 1'b1;
            end
            TB_UNUSED: begin
                used = 1'b0;
            end
        endcase
        return used;
    endfunction : tb_code_used

    // Routes the oscillator pin: bit 1 selects the bus clock, bit 0 the crystal output.
    function automatic logic [1:0] osc_pin_route(input base_osc_t sel);
        logic [1:0] route;
        route = 2'h0;
        unique case (sel)
            OSC_UNUSED: begin
                route = 2'h0;
            end
            OSC_INTERNAL: begin
                route = 2'h2;
            end
            OSC_RC: begin
                route = 2'h2;
            end
            OSC_CRYSTAL: begin
                route = 2'h1;
            end
        endcase
        return route;
    endfunction : osc_pin_route

    // ----------------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------------
    bus_state_t bus_state_r;
    logic hit_a;
    logic hit_b;
    logic hit_nvb;
    logic mapped;
    logic lane0;
    logic take;
    logic [7:0] opt_a_r;
    logic [7:0] opt_b_r;
    logic a_written_r;
    logic b_written_r;
    logic [7:0] nvb_r = `NVB_ERASED;
    logic [7:0] rd_mux;

    // Registers sit in the low byte lane of each word.
    assign hit_a = addr_hit(avs_address, `OPT_A_ADDR);
    assign hit_b = addr_hit(avs_address, `OPT_B_ADDR);
    assign hit_nvb = addr_hit(avs_address, `OPT_NVB_ADDR);
    assign mapped = hit_a | hit_b | hit_nvb;
    assign lane0 = avs_byteenable[0];
    assign take = (bus_state_r == BUS_ANSWER) && avs_write && lane0;

    // Each request is answered on the second edge after it appears.
    always_ff @(posedge mclk) begin
        if (reset) begin
            bus_state_r <= BUS_IDLE;
        end else begin
            unique case (bus_state_r)
                BUS_IDLE: begin
                    if (avs_read || avs_write) begin
                        bus_state_r <= BUS_ANSWER;
                    end
                end
                BUS_ANSWER: begin
                    bus_state_r <= BUS_DONE;
                end
                BUS_DONE: begin
                    bus_state_r <= BUS_IDLE;
                end
                default: begin
                    bus_state_r <= BUS_IDLE;
                end
            endcase
        end
    end

    assign avs_waitrequest = (avs_read || avs_write) && (bus_state_r != BUS_ANSWER);

    always_comb begin
        rd_mux = 8'h00;
        if (hit_a) begin
            rd_mux = opt_a_r;
        end else if (hit_b) begin
            rd_mux = opt_b_r;
        end else if (hit_nvb) begin
            rd_mux = nvb_r;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            avs_readdata <= 32'h0000_0000;
            avs_response <= 2'h0;
        end else if (bus_state_r == BUS_IDLE && (avs_read || avs_write)) begin
            avs_readdata <= {24'h00_0000, rd_mux};
            avs_response <= mapped ? 2'h0 : 2'h3;
        end
    end

    // ----------------------------------------------------------------------
    // Write-once registers
    // ----------------------------------------------------------------------
    write_once_reg u_opt_a (
        .mclk(mclk),
        .reset(reset),
        .wr_en(take && hit_a),
        .wr_data(avs_writedata[7:0]),
        .wr_mask(8'hFF),
        .value_r(opt_a_r),
        .written_r(a_written_r)
    );

    write_once_reg u_opt_b (
        .mclk(mclk),
        .reset(reset),
        .wr_en(take && hit_b),
        .wr_data(avs_writedata[7:0]),
        .wr_mask(`B_WRITE_MASK),
        .value_r(opt_b_r),
        .written_r(b_written_r)
    );

    // ----------------------------------------------------------------------
    // Non-volatile byte
    // ----------------------------------------------------------------------
    // The bus reset does not touch this copy; only the flash load does.
    always_ff @(posedge mclk) begin
        if (nv_load) begin
            nvb_r <= nv_option_byte;
        end
    end

    // ----------------------------------------------------------------------
    // Register A fields
    // ----------------------------------------------------------------------
    // Named views of the bits keep every field position in the map header.
    logic wdog_period_bit;
    logic mon_stop_en_bit;
    logic mon_rst_dis_bit;
    logic supply_dis_bit;
    logic reg_dis_bit;
    logic short_rec_bit;
    logic stop_en_bit;
    logic wdog_dis_bit;

    assign wdog_period_bit = opt_a_r[`A_WDOG_PERIOD];
    assign mon_stop_en_bit = opt_a_r[`A_MON_STOP_EN];
    assign mon_rst_dis_bit = opt_a_r[`A_MON_RST_DIS];
    assign supply_dis_bit = opt_a_r[`A_SUPPLY_DIS];
    assign reg_dis_bit = opt_a_r[`A_REG_DIS];
    assign short_rec_bit = opt_a_r[`A_SHORT_REC];
    assign stop_en_bit = opt_a_r[`A_STOP_EN];
    assign wdog_dis_bit = opt_a_r[`A_WDOG_DIS];

    // ----------------------------------------------------------------------
    // Register B fields
    // ----------------------------------------------------------------------
    // Bits 2 and 1 are not stored, so they have no view here.
    logic iosc_stop_dis_bit;
    logic rc_stop_keep_bit;
    logic crystal_stop_keep_bit;
    timebase_src_t tb_code;
    logic baud_src_bit;

    assign iosc_stop_dis_bit = opt_b_r[`B_IOSC_STOP_DIS];
    assign rc_stop_keep_bit = opt_b_r[`B_RC_STOP_KEEP];
    assign crystal_stop_keep_bit = opt_b_r[`B_CRYSTAL_STOP_KEEP];
    assign tb_code = timebase_src_t'({opt_b_r[`B_TB_SRC_HI], opt_b_r[`B_TB_SRC_LO]});
    assign baud_src_bit = opt_b_r[`B_BAUD_SRC];

    // ----------------------------------------------------------------------
    // Non-volatile byte fields
    // ----------------------------------------------------------------------
    base_osc_t osc_code;
    logic [1:0] pin_route;

    assign osc_code = base_osc_t'(nvb_r[7:6]);
    assign pin_route = osc_pin_route(osc_code);

    // ----------------------------------------------------------------------
    // Watchdog and low-voltage monitor
    // ----------------------------------------------------------------------
    assign watchdog_timeout_cycles = wdog_cycles(wdog_period_bit);
    assign watchdog_module_enable = !wdog_dis_bit;
    assign supply_monitor_enable = !supply_dis_bit;
    assign regulator_monitor_enable = !reg_dis_bit;
    assign low_voltage_monitor_stop_run =
        mon_stop_runs(mon_stop_en_bit, supply_dis_bit, reg_dis_bit);
    // Software is expected to block this path before a stop that leaves the monitor off.
    assign monitor_reset_out = monitor_reset_req && !mon_rst_dis_bit;

    // ----------------------------------------------------------------------
    // Stop instruction and recovery
    // ----------------------------------------------------------------------
    assign stop_recovery_cycles = rec_cycles(short_rec_bit, stop_exit_by_pin);

    // A stop opcode seen while stop is disabled is flagged rather than executed.
    always_comb begin
        stop_execute = 1'b0;
        illegal_opcode = 1'b0;
        if (stop_opcode) begin
            if (stop_en_bit) begin
                stop_execute = 1'b1;
            end else begin
                illegal_opcode = 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------------
    // Oscillators, timebase and serial clock
    // ----------------------------------------------------------------------
    assign internal_osc_stop_run = !iosc_stop_dis_bit;
    // The internal oscillator has no off switch outside stop, whatever the base clock is.
    assign internal_osc_run = 1'b1;
    assign rc_osc_stop_run = rc_stop_keep_bit;
    assign crystal_osc_stop_run = crystal_stop_keep_bit;
    assign timebase_source_clock = tb_code;
    assign timebase_source_valid = tb_code_used(tb_code);
    assign serial_baud_from_bus = baud_src_bit;
    assign oscillator_base_clock = osc_code;
    assign osc_output_pin_from_bus = pin_route[1];
    assign osc_output_pin_from_crystal = pin_route[0];
endmodule : system_option_registers

/* src/sysopt_map.svh */
// Offsets, field positions, reset values and timing counts of the option registers.
// Assumes inclusion from one package or module; definitions only.
`ifndef SYSOPT_MAP_SVH
`define SYSOPT_MAP_SVH

// --------------------------------------------------------------------------
// Register indices and byte addresses
// --------------------------------------------------------------------------
`define OPT_B_INDEX 16'h001D
`define OPT_A_INDEX 16'h001F
`define OPT_NVB_INDEX 16'h0020
`define OPT_B_ADDR 18'h0_0074
`define OPT_A_ADDR 18'h0_007C
`define OPT_NVB_ADDR 18'h0_0080

// --------------------------------------------------------------------------
// Register A fields
// --------------------------------------------------------------------------
`define A_WDOG_PERIOD 7
`define A_MON_STOP_EN 6
`define A_MON_RST_DIS 5
`define A_SUPPLY_DIS 4
`define A_REG_DIS 3
`define A_SHORT_REC 2
`define A_STOP_EN 1
`define A_WDOG_DIS 0

// --------------------------------------------------------------------------
// Register B fields
// --------------------------------------------------------------------------
`define B_IOSC_STOP_DIS 7
`define B_RC_STOP_KEEP 6
`define B_CRYSTAL_STOP_KEEP 5
`define B_TB_SRC_HI 4
`define B_TB_SRC_LO 3
`define B_BAUD_SRC 0
`define B_WRITE_MASK 8'hF9

// --------------------------------------------------------------------------
// Reset values and timing counts
// --------------------------------------------------------------------------
`define OPT_RESET 8'h00
`define NVB_ERASED 8'hFF
`define WDOG_SHORT_CYC 19'h0_1FF0
`define WDOG_LONG_CYC 19'h3_FFF0
`define REC_SHORT_CYC 13'h0020
`define REC_LONG_CYC 13'h1000

`endif

/* src/sysopt_pkg.sv */
// Types shared by the option register bank.
// Assumes nothing of its surroundings.
package sysopt_pkg;
    typedef enum logic [1:0] {
        TB_INTERNAL = 2'h0,
        TB_RC = 2'h1,
        TB_CRYSTAL = 2'h2,
        TB_UNUSED = 2'h3
    } timebase_src_t;

    typedef enum logic [1:0] {
        OSC_UNUSED = 2'h0,
        OSC_INTERNAL = 2'h1,
        OSC_RC = 2'h2,
        OSC_CRYSTAL = 2'h3
    } base_osc_t;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_ANSWER = 3'b010,
        BUS_DONE = 3'b100
    } bus_state_t;
endpackage : sysopt_pkg

/* src/write_once_reg.sv */
// One eight-bit option register that accepts only its first write after reset.
// Assumes a synchronous active-high reset on mclk.
`timescale 1ns/1ps
module write_once_reg
    import sysopt_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Write port
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] wr_mask,
    // State
    output logic [7:0] value_r,
    output logic written_r
);
    // ----------------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            value_r <= 8'h00;
        end else if (wr_en && !written_r) begin
            value_r <= wr_data & wr_mask;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            written_r <= 1'b0;
        end else if (wr_en) begin
            written_r <= 1'b1;
        end
    end
endmodule : write_once_reg

/* verif/sysopt_properties.sv */
// Concurrent checks on the option register bank ports.
// Assumes one bus wait cycle per request and a synchronous high reset.
`timescale 1ns/1ps
module sysopt_checker
    import sysopt_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Bus
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    // Core events and option levels
    input wire logic monitor_reset_req,
    input wire logic monitor_reset_out,
    input wire logic stop_opcode,
    input wire logic stop_execute,
    input wire logic illegal_opcode,
    input wire logic stop_exit_by_pin,
    input wire logic [12:0] stop_recovery_cycles,
    input wire logic [18:0] watchdog_timeout_cycles,
    input wire timebase_src_t timebase_source_clock,
    input wire logic timebase_source_valid
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    bus_one_wait_a: assert property ($rose(avs_read) || $rose(avs_write) |->
        avs_waitrequest ##1 !avs_waitrequest) else $error("bus answer not after one wait");
    reset_clear_a: assert property ($past(reset) |-> watchdog_timeout_cycles == 19'h3_FFF0
        && stop_recovery_cycles == 13'h1000) else $error("options not cleared by reset");
    write_once_a: assert property (!$past(avs_write) && !$past(reset) |->
        $stable(timebase_source_clock) && $stable(watchdog_timeout_cycles))
        else $error("option changed without a write");
    wdog_period_a: assert property (watchdog_timeout_cycles inside
        {19'h0_1FF0, 19'h3_FFF0}) else $error("bad watchdog period");
    pin_exit_long_a: assert property (stop_exit_by_pin |->
        stop_recovery_cycles == 13'h1000) else $error("pin exit not long recovery");
    mon_reset_a: assert property (!monitor_reset_req |-> !monitor_reset_out)
        else $error("monitor reset without request");
    stop_decode_a: assert property (stop_opcode |-> stop_execute != illegal_opcode)
        else $error("stop opcode decode wrong");
    tb_valid_a: assert property (timebase_source_valid ==
        (timebase_source_clock != TB_UNUSED)) else $error("timebase valid wrong");
    cover property (stop_exit_by_pin && stop_opcode);
    cover property (timebase_source_clock == TB_UNUSED);
    cover property ($rose(avs_write));
endmodule : sysopt_checker

bind system_option_registers sysopt_checker sysopt_checker_i (.mclk, .reset, .avs_read,
    .avs_write, .avs_waitrequest, .monitor_reset_req, .monitor_reset_out, .stop_opcode,
    .stop_execute, .illegal_opcode, .stop_exit_by_pin, .stop_recovery_cycles,
    .watchdog_timeout_cycles, .timebase_source_clock, .timebase_source_valid);

/* verif/flash_image_model.sv */
// Flash image that presents the non-volatile oscillator byte.
// Assumes the bench requests programming one cycle at a time.
`timescale 1ns/1ps
module flash_image_model (
    // Clock
    input wire logic mclk,
    // Programming request
    input wire logic [1:0] osc_sel,
    input wire logic program_req,
    // Byte to the bank
    output logic [7:0] nv_option_byte = 8'hFF,
    output logic nv_load = 1'b0
);
    always_ff @(posedge mclk) begin
        nv_load <= program_req;
        nv_option_byte <= {osc_sel, 6'h3F};
    end
endmodule : flash_image_model

/* verif/testbench.sv */
// Self-checking bench of the option register bank.
// Assumes the flash image model and the bound checker.
`timescale 1ns/1ps
module testbench;
    import sysopt_pkg::*;
    logic mclk = 0, reset = 1, avs_read = 0, avs_write = 0, avs_waitrequest;
    logic [17:0] avs_address = 0;
    logic [31:0] avs_writedata = 0, avs_readdata;
    logic [3:0] avs_byteenable = 4'hF;
    logic [1:0] avs_response, osc_sel = 0;
    logic [7:0] nv_option_byte, q;
    logic nv_load, program_req = 0, stop_opcode = 0, monitor_reset_req = 0, stop_exit_by_pin = 0;
    logic [18:0] watchdog_timeout_cycles;
    logic [12:0] stop_recovery_cycles;
    logic watchdog_module_enable, supply_monitor_enable, regulator_monitor_enable;
    logic low_voltage_monitor_stop_run, monitor_reset_out, stop_execute, illegal_opcode;
    logic internal_osc_stop_run, internal_osc_run, rc_osc_stop_run, crystal_osc_stop_run;
    logic timebase_source_valid, serial_baud_from_bus, osc_output_pin_from_bus;
    logic osc_output_pin_from_crystal;
    timebase_src_t timebase_source_clock;
    base_osc_t oscillator_base_clock;
    int errors = 0, checks_done = 0;
    always #2 mclk = ~mclk;
    system_option_registers system_option_registers_i (.*);
    flash_image_model flash_image_model_i (.*);
    task results;
        if (errors == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : results
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task bus(input logic wr, input logic [17:0] a, input logic [7:0] d);
        int n;
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= {24'h00_0000, d};
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        q = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 20) begin
            errors++;
            results();
        end
    endtask : bus
    task settle;
        @(negedge mclk);
    endtask : settle
    task do_reset;
        @(posedge mclk);
        reset <= 1'b1;
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
    endtask : do_reset
    task t_opt_a(input logic [7:0] v);
        do_reset();
        bus(1'b1, 18'h0_007C, v);
        bus(1'b1, 18'h0_007C, ~v);
        bus(1'b0, 18'h0_007C, 8'h00);
        chk(q, v);
        stop_opcode <= 1'b1;
        monitor_reset_req <= 1'b1;
        settle();
        chk(watchdog_timeout_cycles, v[7] ? 19'h0_1FF0 : 19'h3_FFF0);
        chk(stop_recovery_cycles, v[2] ? 13'h0020 : 13'h1000);
        chk({supply_monitor_enable, regulator_monitor_enable}, {!v[4], !v[3]});
        chk(low_voltage_monitor_stop_run, v[6] && !(v[4] && v[3]));
        chk(monitor_reset_out, !v[5]);
        chk({stop_execute, illegal_opcode}, {v[1], !v[1]});
        chk(watchdog_module_enable, !v[0]);
        @(posedge mclk);
        stop_exit_by_pin <= 1'b1;
        settle();
        chk(stop_recovery_cycles, 13'h1000);
        @(posedge mclk);
        {stop_opcode, monitor_reset_req, stop_exit_by_pin} <= 3'h0;
    endtask : t_opt_a
    task t_opt_b(input logic [1:0] k);
        logic [7:0] v;
        v = {k[0], k[1], !k[0], k, 2'b11, k[1]};
        do_reset();
        bus(1'b1, 18'h0_0074, v);
        bus(1'b1, 18'h0_0074, ~v);
        bus(1'b0, 18'h0_0074, 8'h00);
        chk(q, v & 8'hF9);
        settle();
        chk(internal_osc_stop_run, !v[7]);
        chk({rc_osc_stop_run, crystal_osc_stop_run}, v[6:5]);
        chk(timebase_source_clock, k);
        chk(timebase_source_valid, k != 2'h3);
        chk(serial_baud_from_bus, v[0]);
    endtask : t_opt_b
    task t_nv(input logic [1:0] k);
        @(posedge mclk);
        osc_sel <= k;
        program_req <= 1'b1;
        @(posedge mclk);
        program_req <= 1'b0;
        do_reset();
        bus(1'b0, 18'h0_0080, 8'h00);
        chk(q, {k, 6'h3F});
        settle();
        chk(oscillator_base_clock, k);
        chk({osc_output_pin_from_bus, osc_output_pin_from_crystal},
            {k == 2'h1 || k == 2'h2, k == 2'h3});
        chk(internal_osc_run, 1'b1);
    endtask : t_nv
    initial begin
        do_reset();
        bus(1'b0, 18'h0_007C, 8'h00);
        chk(q, 8'h00);
        chk(avs_response, 2'h0);
        bus(1'b0, 18'h0_0074, 8'h00);
        chk(q, 8'h00);
        bus(1'b0, 18'h0_0080, 8'h00);
        chk(q, 8'hFF);
        bus(1'b0, 18'h0_0040, 8'h00);
        chk(avs_response, 2'h3);
        for (int k = 4; k > 0; k--) t_nv(k[1:0]);
        t_opt_a(8'hA6);
        t_opt_a(8'h79);
        t_opt_a(8'h50);
        for (int k = 0; k < 4; k++) t_opt_b(k[1:0]);
        results();
    end
endmodule : testbench
